// ===== shared/eecc_pkg.sv
package eecc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam int          AXI_AW     = 8;
  localparam logic [7:0]  CMD_OFF    = 8'hb0;
  localparam logic [7:0]  DATA_OFF   = 8'hb4;
  localparam logic [7:0]  MACL_OFF   = 8'hb8;
  localparam logic [7:0]  MACH_OFF   = 8'hbc;
  localparam logic [7:0]  STAT_OFF   = 8'hc0;
  localparam logic [7:0]  MASK_OFF   = 8'hc4;

  // ==========================================================
  // Command register layout
  localparam int          BUSY_BIT   = 31;
  localparam int          OP_LSB     = 28;
  localparam int          OP_W       = 3;
  localparam int          EE_AW      = 8;
  localparam int          EE_DW      = 8;
  localparam int          OP_LANE    = 3;
  localparam int          ADDR_LANE  = 0;
  localparam int          DATA_LANE  = 0;

  // ==========================================================
  // Reset values
  localparam logic [2:0]  OP_RST     = 3'h0;
  localparam logic [7:0]  ADDR_RST   = 8'h00;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam logic [47:0] MAC_RST    = 48'h0;

  // ==========================================================
  // Operation codes
  typedef enum logic [2:0] {
    OP_READ      = 3'b000,
    OP_WR_DIS    = 3'b001,
    OP_WR_EN     = 3'b010,
    OP_WRITE     = 3'b011,
    OP_WR_ALL    = 3'b100,
    OP_ERASE     = 3'b101,
    OP_ERASE_ALL = 3'b110,
    OP_RELOAD    = 3'b111
  } eecc_op_t;

  // ==========================================================
  // Address load and interrupt layout
  localparam logic [7:0]  MAC_MARKER = 8'ha5;
  localparam int          MAC_BYTES  = 6;
  localparam int          IRQ_W      = 3;
  localparam int          IRQ_DONE   = 0;
  localparam int          IRQ_TMO    = 1;
  localparam int          IRQ_MAC    = 2;
  localparam logic [2:0]  MASK_RST   = 3'h0;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ==========================================================
  // Timing
  localparam int          CLK_PERIOD_NS = 5;
  localparam int          TIMEOUT_NS    = 1000000;
  localparam int          TIMEOUT_CYC   = TIMEOUT_NS / CLK_PERIOD_NS;

endpackage

// ===== core/eecc_timeout.sv
module eecc_timeout #(
  parameter int LIMIT = 200000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic run,
  input  wire logic restart,
  output logic      expired
);

  localparam int CW = $clog2(LIMIT + 1);

  logic [CW-1:0] cnt_q;

  // ==========================================================
  // Cycle counter, cleared while idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '0;
    else if (ce)
    begin
      if (!run || restart || expired)
        cnt_q <= '0;
      else
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // Expiry pulse on last counted cycle
  assign expired = ce && run && !restart
                   && (cnt_q == CW'(LIMIT - 1));

endmodule

// ===== core/eecc_irq.sv
module eecc_irq #(
  parameter int W = 3
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] set,
  input  wire logic         rd_clr,
  input  wire logic         mask_wr,
  input  wire logic [W-1:0] mask_wdata,
  output logic [W-1:0]      status,
  output logic [W-1:0]      mask,
  output logic              irq
);

  // ==========================================================
  // Sticky status, a read clears, a new event wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status <= '0;
    else if (ce)
    begin
      if (rd_clr)
        status <= set;
      else
        status <= status | set;
    end
  end

  // Mask register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask <= eecc_pkg::MASK_RST;
    else if (ce && mask_wr)
      mask <= mask_wdata;
  end

  // Level interrupt from registered state
  assign irq = |(status & mask);

endmodule

// ===== core/eecc_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers.
module eecc_top #(
  parameter int TIMEOUT_CYCLES = eecc_pkg::TIMEOUT_CYC
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire logic [eecc_pkg::AXI_AW-1:0]  s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [eecc_pkg::AXI_AW-1:0]  s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic                              eng_valid,
  input  wire logic                         eng_ready,
  output logic [2:0]                        eng_op,
  output logic [eecc_pkg::EE_AW-1:0]        eng_addr,
  output logic [eecc_pkg::EE_DW-1:0]        eng_wdata,
  input  wire logic                         eng_done,
  input  wire logic [eecc_pkg::EE_DW-1:0]   eng_rdata,
  output logic [47:0]                       mac_addr,
  output logic                              mac_loaded,
  output logic                              irq
);

  // ==========================================================
  // Types and helpers
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ISSUE  = 3'b001,
    ST_WAIT   = 3'b010,
    ST_MISSUE = 3'b011,
    ST_MWAIT  = 3'b100
  } eecc_state_t;

  // Word address match
  function automatic logic reg_hit(
    input logic [eecc_pkg::AXI_AW-1:0] addr,
    input logic [eecc_pkg::AXI_AW-1:0] off
  );
    reg_hit = (addr[eecc_pkg::AXI_AW-1:2] == off[eecc_pkg::AXI_AW-1:2]);
  endfunction

  // Any mapped register
  function automatic logic reg_mapped(
    input logic [eecc_pkg::AXI_AW-1:0] addr
  );
    reg_mapped = reg_hit(addr, eecc_pkg::CMD_OFF)
               || reg_hit(addr, eecc_pkg::DATA_OFF)
               || reg_hit(addr, eecc_pkg::MACL_OFF)
               || reg_hit(addr, eecc_pkg::MACH_OFF)
               || reg_hit(addr, eecc_pkg::STAT_OFF)
               || reg_hit(addr, eecc_pkg::MASK_OFF);
  endfunction

  localparam logic [2:0] LAST_IDX = 3'(eecc_pkg::MAC_BYTES);

  eecc_state_t                      state_q;
  logic                             busy_q;
  logic [2:0]                       op_q;
  logic [eecc_pkg::EE_AW-1:0]       addr_q;
  logic [eecc_pkg::EE_DW-1:0]       data_q;
  logic [2:0]                       idx_q;
  logic [47:0]                      mac_q;
  logic                             mac_ok_q;
  logic                             eng_valid_q;
  logic [2:0]                       eng_op_q;
  logic [eecc_pkg::EE_AW-1:0]       eng_addr_q;

  logic                             aw_held_q;
  logic [eecc_pkg::AXI_AW-1:0]      awaddr_q;
  logic                             w_held_q;
  logic [31:0]                      wdata_q;
  logic [3:0]                       wstrb_q;
  logic                             bvalid_q;
  logic [1:0]                       bresp_q;
  logic                             rvalid_q;
  logic [1:0]                       rresp_q;
  logic [31:0]                      rdata_q;

  logic                             wr_fire;
  logic                             rd_fire;
  logic                             cmd_wr;
  logic                             go;
  logic                             tmo;
  logic                             op_done;
  logic                             mac_bad;
  logic                             mac_last;
  logic                             op_end;
  logic                             active;
  logic [eecc_pkg::IRQ_W-1:0]       irq_set;
  logic [eecc_pkg::IRQ_W-1:0]       irq_status;
  logic [eecc_pkg::IRQ_W-1:0]       irq_mask;
  logic [31:0]                      rd_word;

  // ==========================================================
  // AXI4-Lite write channels
  assign s_axi_awready = ce && !aw_held_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_held_q && !bvalid_q;
  assign wr_fire       = ce && aw_held_q && w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Write address holding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_q <= 1'b0;
    end
  end

  // Write data holding
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_q <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= eecc_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= reg_mapped(awaddr_q) ? eecc_pkg::RESP_OKAY
                                         : eecc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channels
  assign s_axi_arready = ce && !rvalid_q;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // Read word mux
  always_comb
  begin
    rd_word = '0;
    if (reg_hit(s_axi_araddr, eecc_pkg::CMD_OFF))
    begin
      rd_word[eecc_pkg::BUSY_BIT] = busy_q;
      rd_word[eecc_pkg::OP_LSB +: eecc_pkg::OP_W] = op_q;
      rd_word[eecc_pkg::EE_AW-1:0] = addr_q;
    end
    else if (reg_hit(s_axi_araddr, eecc_pkg::DATA_OFF))
      rd_word[eecc_pkg::EE_DW-1:0] = data_q;
    else if (reg_hit(s_axi_araddr, eecc_pkg::MACL_OFF))
      rd_word = mac_q[31:0];
    else if (reg_hit(s_axi_araddr, eecc_pkg::MACH_OFF))
      rd_word[15:0] = mac_q[47:32];
    else if (reg_hit(s_axi_araddr, eecc_pkg::STAT_OFF))
      rd_word[eecc_pkg::IRQ_W-1:0] = irq_status;
    else if (reg_hit(s_axi_araddr, eecc_pkg::MASK_OFF))
      rd_word[eecc_pkg::IRQ_W-1:0] = irq_mask;
  end

  // Read response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= eecc_pkg::RESP_OKAY;
      rdata_q  <= '0;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= reg_mapped(s_axi_araddr) ? eecc_pkg::RESP_OKAY
                                             : eecc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // Command decode
  assign cmd_wr = wr_fire && reg_hit(awaddr_q, eecc_pkg::CMD_OFF)
                  && !busy_q;
  assign go     = cmd_wr && wstrb_q[eecc_pkg::OP_LANE]
                  && wdata_q[eecc_pkg::BUSY_BIT];

  // Completion events
  assign active   = (state_q != ST_IDLE);
  assign op_done  = (state_q == ST_WAIT) && eng_done;
  assign mac_bad  = (state_q == ST_MWAIT) && eng_done && (idx_q == 3'h0)
                    && (eng_rdata != eecc_pkg::MAC_MARKER);
  assign mac_last = (state_q == ST_MWAIT) && eng_done
                    && (idx_q == LAST_IDX);
  assign op_end   = op_done || tmo || mac_bad || mac_last;

  // Command field and address hold
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      op_q   <= eecc_pkg::OP_RST;
      addr_q <= eecc_pkg::ADDR_RST;
    end
    else if (ce && cmd_wr)
    begin
      if (wstrb_q[eecc_pkg::OP_LANE])
        op_q <= wdata_q[eecc_pkg::OP_LSB +: eecc_pkg::OP_W];
      if (wstrb_q[eecc_pkg::ADDR_LANE])
        addr_q <= wdata_q[eecc_pkg::EE_AW-1:0];
    end
  end

  // Busy flag, high from reset through address load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      busy_q <= 1'b1;
    else if (ce)
    begin
      if (go)
        busy_q <= 1'b1;
      else if (op_end)
        busy_q <= 1'b0;
    end
  end

  // Data register, engine read result wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      data_q <= eecc_pkg::DATA_RST;
    else if (ce)
    begin
      if (op_done && (eng_op_q == eecc_pkg::OP_READ))
        data_q <= eng_rdata;
      else if (wr_fire && reg_hit(awaddr_q, eecc_pkg::DATA_OFF)
               && wstrb_q[eecc_pkg::DATA_LANE])
        data_q <= wdata_q[eecc_pkg::EE_DW-1:0];
    end
  end

  // ==========================================================
  // Operation sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= ST_MISSUE;
    else if (ce)
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (go)
          begin
            if (wdata_q[eecc_pkg::OP_LSB +: eecc_pkg::OP_W]
                == eecc_pkg::OP_RELOAD)
              state_q <= ST_MISSUE;
            else
              state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          if (tmo)
            state_q <= ST_IDLE;
          else if (eng_ready)
            state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (op_done || tmo)
            state_q <= ST_IDLE;
        end
        ST_MISSUE:
        begin
          if (tmo)
            state_q <= ST_IDLE;
          else if (eng_ready)
            state_q <= ST_MWAIT;
        end
        ST_MWAIT:
        begin
          if (tmo || mac_bad || mac_last)
            state_q <= ST_IDLE;
          else if (eng_done)
            state_q <= ST_MISSUE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Engine request valid
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      eng_valid_q <= 1'b1;
    else if (ce)
    begin
      if (go || ((state_q == ST_MWAIT) && eng_done && !op_end))
        eng_valid_q <= 1'b1;
      else if (eng_ready || tmo)
        eng_valid_q <= 1'b0;
    end
  end

  // Engine request payload
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      eng_op_q   <= eecc_pkg::OP_READ;
      eng_addr_q <= eecc_pkg::ADDR_RST;
    end
    else if (ce)
    begin
      if (go)
      begin
        eng_op_q <= wdata_q[eecc_pkg::OP_LSB +: eecc_pkg::OP_W];
        if (wstrb_q[eecc_pkg::ADDR_LANE])
          eng_addr_q <= wdata_q[eecc_pkg::EE_AW-1:0];
        else
          eng_addr_q <= addr_q;
        if (wdata_q[eecc_pkg::OP_LSB +: eecc_pkg::OP_W]
            == eecc_pkg::OP_RELOAD)
          eng_addr_q <= eecc_pkg::ADDR_RST;
      end
      else if ((state_q == ST_MWAIT) && eng_done)
        eng_addr_q <= eecc_pkg::EE_AW'(idx_q + 3'h1);
    end
  end

  // Load engine as a read for address load
  assign eng_op    = (state_q == ST_MISSUE || state_q == ST_MWAIT)
                     ? eecc_pkg::OP_READ : eng_op_q;
  assign eng_valid = eng_valid_q;
  assign eng_addr  = eng_addr_q;
  assign eng_wdata = data_q;

  // ==========================================================
  // Address load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      idx_q <= 3'h0;
    else if (ce)
    begin
      if (go)
        idx_q <= 3'h0;
      else if ((state_q == ST_MWAIT) && eng_done)
        idx_q <= idx_q + 3'h1;
    end
  end

  // Loaded flag, cleared when a reload starts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mac_ok_q <= 1'b0;
    else if (ce)
    begin
      if (go && (wdata_q[eecc_pkg::OP_LSB +: eecc_pkg::OP_W]
                 == eecc_pkg::OP_RELOAD))
        mac_ok_q <= 1'b0;
      else if (mac_last)
        mac_ok_q <= 1'b1;
    end
  end

  // One byte lane per address location
  genvar g;
  generate
    for (g = 0; g < eecc_pkg::MAC_BYTES; g++)
    begin : g_mac
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          mac_q[g*8 +: 8] <= eecc_pkg::MAC_RST[g*8 +: 8];
        else if (ce && (state_q == ST_MWAIT) && eng_done
                 && (idx_q == 3'(g + 1)))
          mac_q[g*8 +: 8] <= eng_rdata;
      end
    end
  endgenerate

  assign mac_addr   = mac_q;
  assign mac_loaded = mac_ok_q;

  // ==========================================================
  // Timeout and interrupts
  eecc_timeout #(
    .LIMIT   (TIMEOUT_CYCLES)
  ) u_timeout (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (active),
    .restart (eng_done || go),
    .expired (tmo)
  );

  assign irq_set[eecc_pkg::IRQ_DONE] = op_end;
  assign irq_set[eecc_pkg::IRQ_TMO]  = tmo;
  assign irq_set[eecc_pkg::IRQ_MAC]  = mac_last;

  eecc_irq #(
    .W          (eecc_pkg::IRQ_W)
  ) u_irq (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ce         (ce),
    .set        (irq_set),
    .rd_clr     (rd_fire && reg_hit(s_axi_araddr, eecc_pkg::STAT_OFF)),
    .mask_wr    (wr_fire && reg_hit(awaddr_q, eecc_pkg::MASK_OFF)
                 && wstrb_q[0]),
    .mask_wdata (wdata_q[eecc_pkg::IRQ_W-1:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

endmodule

// ===== dv/eecc_engine_model.sv
module eecc_engine_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       absent,
  input  wire logic       eng_valid,
  input  wire logic [2:0] eng_op,
  input  wire logic [7:0] eng_addr,
  input  wire logic [7:0] eng_wdata,
  output logic            eng_ready,
  output logic            eng_done,
  output logic [7:0]      eng_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem_q [256];
  logic       act_q;
  logic       wen_q;
  logic [3:0] cnt_q;
  logic [7:0] addr_q;
  logic [2:0] op_q;

  // ==========================================================
  // Memory content before any host write, marker at location 0
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem_q[i] = 8'h10 + 8'(i);
    mem_q[0] = 8'ha5;
  end

  // Accept at once, work six cycles, then report done
  always @(posedge aclk)
  begin
    eng_ready <= 1'b0;
    eng_done  <= 1'b0;
    eng_rdata <= ~eng_rdata;  // Released line keeps changing
    if (!aresetn)
    begin
      act_q     <= 1'b0;
      wen_q     <= 1'b0;
      eng_rdata <= 8'h5a;
    end
    else if (!act_q)
    begin
      if (eng_valid && !absent)
      begin
        eng_ready <= 1'b1;
        act_q     <= 1'b1;
        addr_q    <= eng_addr;
        op_q      <= eng_op;
        cnt_q     <= 4'h6;
      end
    end
    else if (cnt_q != 4'h0)
      cnt_q <= cnt_q - 4'h1;
    else
    begin
      act_q     <= 1'b0;
      eng_done  <= 1'b1;
      eng_rdata <= mem_q[addr_q];
      // Erase and write only when enabled
      case (op_q)
        3'h1: wen_q <= 1'b0;
        3'h2: wen_q <= 1'b1;
        3'h3: if (wen_q) mem_q[addr_q] <= eng_wdata;
        3'h4: if (wen_q) for (int i = 0; i < 256; i++) mem_q[i] <= eng_wdata;
        3'h5: if (wen_q) mem_q[addr_q] <= 8'hff;
        3'h6: if (wen_q) for (int i = 0; i < 256; i++) mem_q[i] <= 8'hff;
        default: ;
      endcase
    end
  end
endmodule

// ===== dv/eecc_top_checker.sv
module eecc_top_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        eng_valid,
  input wire logic        eng_ready,
  input wire logic        eng_done,
  input wire logic [2:0]  eng_op,
  input wire logic [7:0]  eng_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ==========================================================
  // Engine request side
  a_load_start: assert property (
    $rose(aresetn) |-> eng_valid && eng_addr == 8'h00 && eng_op == 3'h0)
    else $error("address load not started after reset");
  a_req_hold: assert property (
    eng_valid && !eng_ready |=> !eng_valid || ($stable(eng_op)
      && $stable(eng_addr)))
    else $error("engine request changed while waiting");
  a_req_drop: assert property (
    eng_valid && eng_ready |=> !eng_valid)
    else $error("engine request kept after acceptance");
  a_done_quiet: assert property (
    eng_done |-> !eng_valid)
    else $error("new engine request before done");

  // ==========================================================
  // Register bus answers
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_resp_block: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_ar_block: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_unmapped_rd: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
      |=> s_axi_rresp == eecc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind eecc_top eecc_top_checker chk_u (.*);

// ===== dv/eeprom_command_control_bench.sv
module eeprom_command_control_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic        aclk, aresetn, ce, absent, irq, mac_loaded;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, eng_addr, eng_wdata, eng_rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, eng_valid, eng_ready, eng_done;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  eng_op;
  logic [47:0] mac_addr;
  int          fails, checked;

  eecc_top #(.TIMEOUT_CYCLES(50)) dut_u (.*);
  eecc_engine_model eng_u (.*);

  // ==========================================================
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    b_t = 1'b0;
    for (int n = 0; n < 50 && !b_t; n++)
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      if (b_t) s_axi_bready <= 1'b0;
    end
    if (!b_t)
    begin
      fails++;
      test_done();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a);
    logic ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r_t = 1'b0;
    for (int n = 0; n < 50 && !r_t; n++)
    begin
      @(negedge aclk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      if (r_t) s_axi_rready <= 1'b0;
    end
    if (!r_t)
    begin
      fails++;
      test_done();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    check(d, e);
  endtask

  task automatic wait_idle;
    d = 32'hffff_ffff;
    for (int n = 0; n < 60 && d[31]; n++)
      axi_rd(eecc_pkg::CMD_OFF);
    if (d[31])
    begin
      fails++;
      test_done();
    end
  endtask

  task automatic go(input logic [2:0] op, input logic [7:0] a);
    axi_wr(eecc_pkg::CMD_OFF, {1'b1, op, 20'h0, a});
    wait_idle();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(eecc_pkg::CMD_OFF, 32'h8000_0000);
    wait_idle();
    check(mac_loaded, 1);
    check(mac_addr, 48'h1615_1413_1211);
    rd_chk(eecc_pkg::MACL_OFF, 32'h1413_1211);
    rd_chk(eecc_pkg::CMD_OFF, 32'h0);
    axi_rd(8'h20);
    check(r, eecc_pkg::RESP_SLVERR);
    axi_wr(8'h20, 32'h1);
    check(r, eecc_pkg::RESP_SLVERR);
  endtask

  task automatic t_busy_ignore;
    axi_wr(eecc_pkg::DATA_OFF, 32'h66);
    axi_wr(eecc_pkg::CMD_OFF, 32'h8000_0007);
    axi_wr(eecc_pkg::CMD_OFF, 32'hb000_0007);
    check(r, eecc_pkg::RESP_OKAY);
    wait_idle();
    rd_chk(eecc_pkg::CMD_OFF, 32'h0000_0007);
    rd_chk(eecc_pkg::DATA_OFF, 32'h17);
  endtask

  task automatic t_ops;
    go(eecc_pkg::OP_WR_EN, 8'h0);
    axi_wr(eecc_pkg::DATA_OFF, 32'h3c);
    go(eecc_pkg::OP_WRITE, 8'h05);
    go(eecc_pkg::OP_READ, 8'h05);
    rd_chk(eecc_pkg::DATA_OFF, 32'h3c);
    go(eecc_pkg::OP_WR_DIS, 8'h0);
    axi_wr(eecc_pkg::DATA_OFF, 32'h77);
    go(eecc_pkg::OP_WRITE, 8'h05);
    go(eecc_pkg::OP_READ, 8'h05);
    rd_chk(eecc_pkg::DATA_OFF, 32'h3c);
    go(eecc_pkg::OP_WR_EN, 8'h0);
    axi_wr(eecc_pkg::DATA_OFF, 32'h5a);
    go(eecc_pkg::OP_WR_ALL, 8'h0);
    go(eecc_pkg::OP_ERASE, 8'h09);
    go(eecc_pkg::OP_READ, 8'h08);
    rd_chk(eecc_pkg::DATA_OFF, 32'h5a);
    go(eecc_pkg::OP_READ, 8'h09);
    rd_chk(eecc_pkg::DATA_OFF, 32'hff);
    go(eecc_pkg::OP_ERASE_ALL, 8'h0);
    go(eecc_pkg::OP_RELOAD, 8'h0);
    check(mac_loaded, 0);
    axi_wr(eecc_pkg::DATA_OFF, 32'ha5);
    go(eecc_pkg::OP_WRITE, 8'h00);
    go(eecc_pkg::OP_RELOAD, 8'h0);
    check(mac_loaded, 1);
    rd_chk(eecc_pkg::MACL_OFF, 32'hffff_ffff);
  endtask

  task automatic t_timeout;
    axi_wr(eecc_pkg::MASK_OFF, 32'h2);
    check(irq, 0);
    absent <= 1'b1;
    axi_wr(eecc_pkg::CMD_OFF, 32'hb000_0003);
    repeat (35) @(posedge aclk);
    rd_chk(eecc_pkg::CMD_OFF, 32'hb000_0003);
    wait_idle();
    check(irq, 1);
    axi_rd(eecc_pkg::STAT_OFF);
    check(d & 32'h2, 32'h2);
    check(irq, 0);
    absent <= 1'b0;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {aresetn, absent, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    ce = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_busy_ignore();
    t_ops();
    t_timeout();
    test_done();
  end
endmodule
